// >>> hdl/flash_security_protection.sv
// flash security, backdoor key and block protection control with axi4-lite
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_defs.svh"
module flash_security_protection (
	input  wire logic                 clock,
	input  wire logic                 nrst,
	input  wire logic [7:0]           awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [7:0]           araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	input  wire logic                 debug_source,
	input  wire logic [7:0]           nv_option,
	input  wire logic [7:0]           nv_protect,
	input  wire logic [63:0]          nv_key,
	input  wire logic                 kw_valid,
	input  wire logic [15:0]          kw_addr,
	input  wire logic [7:0]           kw_data,
	input  wire logic                 kw_from_debug,
	output logic                      prog_start,
	output logic [15:0]               prog_addr,
	output logic [7:0]                prog_data,
	input  wire logic                 cmd_valid,
	input  wire logic [15:0]          cmd_addr,
	output logic                      cmd_accept,
	output logic                      cmd_refused,
	input  wire logic                 blank_done,
	input  wire logic                 blank_erased,
	input  wire logic                 unsecured_req,
	output logic                      access_block,
	output logic                      secured,
	output logic                      vector_redirect_en,
	output logic                      protection_violation_flag
);
	import flash_sec_pkg::*;

	sec_s s_q;
	sec_s s_d;

	logic [7:0]  key_we;
	logic [7:0]  key_eq;
	logic        all_match;
	logic        wr_fire;
	logic        rd_fire;
	logic        in_key_range;
	logic        key_close;
	logic        key_open;
	logic        prot_hit;
	logic        unlock_key;
	logic        unlock_blank;
	logic [31:0] rd_word;
	logic [1:0]  rd_resp;
	logic [7:0]  cfg_rd;
	logic [7:0]  stat_rd;

	// entered key bytes, one slot per byte, first byte in the low lane
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_key
			key_byte_slot u_slot (
				.clock  (clock),
				.nrst   (nrst),
				.load   (key_we[gi]),
				.din    (kw_data),
				.stored (nv_key[gi*8 +: 8]),
				.match  (key_eq[gi])
			);
		end
	endgenerate

	assign all_match = &key_eq;

	always_comb begin
		wr_fire = awvalid & wvalid & ~s_q.bvalid & (s_q.st == st_run);
		rd_fire = arvalid & ~s_q.rvalid & (s_q.st == st_run);
		in_key_range = (kw_addr[15:3] == `KEY_BASE_HI);
		key_open = wr_fire & wstrb[0] & (awaddr == `OFS_CONFIG)
			& ~s_q.steer & wdata[`CFG_STEER];
		key_close = wr_fire & wstrb[0] & (awaddr == `OFS_CONFIG)
			& s_q.steer & ~wdata[`CFG_STEER];
		// protected area lies above the last unprotected page
		prot_hit = ~s_q.prot[`PROT_DIS]
			& (cmd_addr > {s_q.prot[7:1], `PROT_PAGE_MASK});
		unlock_key = key_close & s_q.opt[`OPT_KEY_EN] & ~s_q.kbad
			& (s_q.kidx == `KEY_COUNT) & all_match;
		unlock_blank = blank_done & blank_erased & (s_q.st == st_run);
	end

	assign awready = wr_fire;
	assign wready  = wr_fire;
	assign arready = rd_fire;

	always_comb begin
		cfg_rd = 8'h00;
		cfg_rd[`CFG_STEER] = s_q.steer;
		stat_rd = 8'h00;
		stat_rd[`STAT_VIOL] = s_q.viol;
		stat_rd[`STAT_SECURED] = secured;
		rd_resp = `RESP_OKAY;
		case (araddr)
			`OFS_OPTION: begin
				rd_word = {24'h000000, s_q.opt};
			end
			`OFS_CONFIG: begin
				rd_word = {24'h000000, cfg_rd};
			end
			`OFS_PROTECT: begin
				rd_word = {24'h000000, s_q.prot};
			end
			`OFS_STATUS: begin
				rd_word = {24'h000000, stat_rd};
			end
			default: begin
				rd_word = 32'h00000000;
				rd_resp = `RESP_SLVERR;
			end
		endcase
	end

	always_comb begin
		s_d = s_q;
		key_we = 8'h00;
		s_d.pstart = 1'b0;
		s_d.cacc = 1'b0;
		s_d.cref = 1'b0;
		case (s_q.st)
			st_load: begin
				s_d.opt = nv_option;
				s_d.prot = nv_protect;
				s_d.st = st_run;
			end
			st_run: begin
				if (s_q.bvalid && bready) begin
					s_d.bvalid = 1'b0;
				end
				if (s_q.rvalid && rready) begin
					s_d.rvalid = 1'b0;
				end
				if (rd_fire) begin
					s_d.rvalid = 1'b1;
					s_d.rdata = rd_word;
					s_d.rresp = rd_resp;
				end
				if (wr_fire) begin
					s_d.bvalid = 1'b1;
					s_d.bresp = `RESP_OKAY;
					case (awaddr)
						`OFS_OPTION: begin
							// read only; reset loads the value and an unlock sets bits 1:0
							s_d.bresp = `RESP_OKAY;
						end
						`OFS_CONFIG: begin
							if (wstrb[0]) begin
								s_d.steer = wdata[`CFG_STEER];
							end
						end
						`OFS_PROTECT: begin
							// debug only, tighten only, frozen when disabled
							if (wstrb[0] && debug_source
								&& !s_q.prot[`PROT_DIS]
								&& (wdata[7:1] < s_q.prot[7:1])) begin
								s_d.prot[7:1] = wdata[7:1];
							end
						end
						`OFS_STATUS: begin
							if (wstrb[0] && wdata[`STAT_VIOL]) begin
								s_d.viol = 1'b0;
							end
						end
						default: begin
							s_d.bresp = `RESP_SLVERR;
						end
					endcase
				end
				if (key_open) begin
					s_d.kidx = 4'h0;
					s_d.kbad = 1'b0;
				end
				if (kw_valid) begin
					if (s_q.steer && in_key_range) begin
						if (kw_from_debug || s_q.kidx[3]
							|| (kw_addr[2:0] != s_q.kidx[2:0])) begin
							s_d.kbad = 1'b1;
						end else begin
							key_we[s_q.kidx[2:0]] = 1'b1;
							s_d.kidx = s_q.kidx + 4'h1;
						end
					end else begin
						s_d.pstart = 1'b1;
						s_d.paddr = kw_addr;
						s_d.pdata = kw_data;
					end
				end
				if (cmd_valid) begin
					if (prot_hit) begin
						s_d.cref = 1'b1;
						s_d.viol = 1'b1;
					end else begin
						s_d.cacc = 1'b1;
					end
				end
				if (unlock_key || unlock_blank) begin
					s_d.opt[1:0] = `SEC_UNSECURED;
				end
			end
			default: begin
				s_d.st = st_load;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign secured = (s_q.opt[1:0] != `SEC_UNSECURED);
	assign access_block = secured & unsecured_req;
	assign vector_redirect_en = ~s_q.opt[`OPT_NORED];
	assign protection_violation_flag = s_q.viol;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;
	assign prog_start = s_q.pstart;
	assign prog_addr = s_q.paddr;
	assign prog_data = s_q.pdata;
	assign cmd_accept = s_q.cacc;
	assign cmd_refused = s_q.cref;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence load_phase;
		s_q.st == st_load;
	endsequence

	sequence good_key_close;
		key_close && s_q.opt[`OPT_KEY_EN] && !s_q.kbad
			&& s_q.kidx == `KEY_COUNT && all_match;
	endsequence

	sequence protected_cmd;
		cmd_valid && prot_hit && s_q.st == st_run;
	endsequence

	a_option_load: assert property (
		load_phase |=> s_q.opt == $past(nv_option)
			&& s_q.prot == $past(nv_protect))
		else $error("option or protection not loaded at reset");

	a_option_stable: assert property (
		s_q.st == st_run |=> $stable(s_q.opt[7:2]))
		else $error("option bits changed outside reset");

	a_key_disabled: assert property (
		key_close && !s_q.opt[`OPT_KEY_EN] && !unlock_blank
			|=> $stable(s_q.opt[1:0]))
		else $error("key unlock with backdoor disabled");

	a_debug_key_drop: assert property (
		kw_valid && kw_from_debug |-> key_we == 8'h00)
		else $error("debug key byte was stored");

	a_key_unlock: assert property (
		good_key_close |=> !secured ##1 !secured)
		else $error("matching key did not unlock");

	a_redirect_map: assert property (
		s_q.st == st_run |=> vector_redirect_en == !$past(s_q.opt[6]))
		else $error("vector redirect does not follow option bit");

	a_block_access: assert property (
		unsecured_req && s_q.opt[1:0] != 2'h2 |-> access_block)
		else $error("secured memory reachable from unsecured source");

	a_blank_unlock: assert property (
		unlock_blank |=> s_q.opt[1:0] == 2'h2)
		else $error("blank check did not unlock");

	a_prot_readback: assert property (
		rd_fire && araddr == `OFS_PROTECT
			|=> rvalid && rdata == {24'h000000, $past(s_q.prot)})
		else $error("protection readback wrong");

	a_prot_tighten: assert property (
		s_q.st == st_run |=> s_q.prot[7:1] <= $past(s_q.prot[7:1]))
		else $error("protection loosened");

	a_prot_frozen: assert property (
		s_q.st == st_run && s_q.prot[`PROT_DIS] |=> $stable(s_q.prot))
		else $error("disabled protection changed");

	a_prot_sw_ignored: assert property (
		s_q.st == st_run && !debug_source |=> $stable(s_q.prot))
		else $error("software changed protection");

	a_viol_refuse: assert property (
		protected_cmd |=> cmd_refused && !cmd_accept
			&& protection_violation_flag)
		else $error("protected command not refused");
endmodule : flash_security_protection
`default_nettype wire

// >>> hdl/key_byte_slot.sv
// one byte of the entered backdoor key and its match against the stored byte
`timescale 1ns/1ps
`default_nettype none
module key_byte_slot (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       load,
	input  wire logic [7:0] din,
	input  wire logic [7:0] stored,
	output logic            match
);
	import flash_sec_pkg::*;

	slot_s s_q;
	slot_s s_d;

	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.b = din;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign match = (s_q.b == stored);
endmodule : key_byte_slot
`default_nettype wire

// >>> inc/flash_sec_defs.svh
// register offsets, field positions and constants of the flash security block
`ifndef FLASH_SEC_DEFS_SVH
`define FLASH_SEC_DEFS_SVH

`define OFS_OPTION      8'h00
`define OFS_CONFIG      8'h04
`define OFS_PROTECT     8'h08
`define OFS_STATUS      8'h0C

`define OPT_KEY_EN      7
`define OPT_NORED       6
`define SEC_UNSECURED   2'h2

`define CFG_STEER       5
`define PROT_DIS        0
`define STAT_VIOL       0
`define STAT_SECURED    1

`define KEY_BASE_HI     13'h1FF6
`define KEY_COUNT       4'h8
`define PROT_PAGE_MASK  9'h1FF

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> inc/flash_sec_pkg.sv
// types shared by the flash security block
package flash_sec_pkg;
	typedef enum logic {st_load, st_run} run_e;

	typedef struct packed {
		run_e        st;
		logic [7:0]  opt;
		logic [7:0]  prot;
		logic        steer;
		logic        viol;
		logic [3:0]  kidx;
		logic        kbad;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        pstart;
		logic [15:0] paddr;
		logic [7:0]  pdata;
		logic        cacc;
		logic        cref;
	} sec_s;

	typedef struct packed {
		logic [7:0] b;
	} slot_s;
endpackage : flash_sec_pkg

// >>> verif/host_side_model.sv
// host-side model driving the flash write, command and blank ports
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
	input  wire logic   clock,
	output logic        kw_valid,
	output logic [15:0] kw_addr,
	output logic [7:0]  kw_data,
	output logic        kw_from_debug,
	output logic        cmd_valid,
	output logic [15:0] cmd_addr,
	output logic        blank_done,
	output logic        blank_erased
);
	initial begin
		{kw_valid, kw_addr, kw_data, kw_from_debug} = '0;
		{cmd_valid, cmd_addr, blank_done, blank_erased} = '0;
	end
	// released lines show the inverse so stale values never match
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic dbg);
		@(posedge clock);
		{kw_valid, kw_addr, kw_data, kw_from_debug} <= {1'b1, a, d, dbg};
		@(posedge clock);
		{kw_valid, kw_addr, kw_data} <= {1'b0, ~a, ~d};
	endtask : wr
	task automatic cmd(input logic [15:0] a);
		@(posedge clock);
		{cmd_valid, cmd_addr} <= {1'b1, a};
		@(posedge clock);
		{cmd_valid, cmd_addr} <= {1'b0, ~a};
	endtask : cmd
	task automatic blank(input logic e);
		@(posedge clock);
		{blank_done, blank_erased} <= {1'b1, e};
		@(posedge clock);
		{blank_done, blank_erased} <= {1'b0, ~e};
	endtask : blank
endmodule : host_side_model
`default_nettype wire

// >>> verif/tb_flash_security_protection.sv
// self-checking bench of the flash security and protection block
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_defs.svh"
module tb_flash_security_protection;
	import flash_sec_pkg::*;
	logic clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, debug_source, kw_valid;
	logic kw_from_debug, prog_start, cmd_valid, cmd_accept, cmd_refused;
	logic blank_done, blank_erased, unsecured_req, access_block, secured;
	logic vector_redirect_en, protection_violation_flag, d;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb;
	logic [7:0]  awaddr, araddr, nv_option, nv_protect, kw_data, prog_data;
	logic [7:0]  prot, opt, wv;
	logic [15:0] kw_addr, prog_addr, cmd_addr, ca;
	logic [31:0] wdata, rdata, seed;
	logic [63:0] nv_key;
	int          err_total, total_checks;

	flash_security_protection dut (.*);
	host_side_model host (.*);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run;
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic axw(input logic [7:0] a, input logic [31:0] v,
		input logic g, input logic [1:0] r);
		@(posedge clock);
		{awvalid, wvalid, awaddr, wdata} <= {2'b11, a, v};
		{debug_source, bready} <= {g, 1'b1};
		do @(negedge clock); while ((awready && wready) !== 1'b1);
		@(posedge clock);
		{awvalid, wvalid, awaddr, wdata} <= {2'b00, ~a, ~v};
		do @(negedge clock); while (bvalid !== 1'b1);
		chk(bresp, r);
		@(posedge clock);
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge clock);
		{arvalid, araddr, rready} <= {1'b1, a, 1'b1};
		do @(negedge clock); while (arready !== 1'b1);
		@(posedge clock);
		{arvalid, araddr} <= {1'b0, ~a};
		do @(negedge clock); while (rvalid !== 1'b1);
		chk(rdata, e);
		chk(rresp, r);
		@(posedge clock);
		rready <= 1'b0;
	endtask : axr

	function automatic logic [7:0] prot_next(input logic [7:0] c,
		input logic [7:0] w, input logic g);
		return (g && !c[0] && w[7:1] < c[7:1]) ? {w[7:1], c[0]} : c;
	endfunction : prot_next

	function automatic logic prot_hit(input logic [7:0] c,
		input logic [15:0] a);
		return !c[0] && a > {c[7:1], 9'h1FF};
	endfunction : prot_hit

	task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
		@(posedge clock);
		{nrst, nv_option, nv_protect} <= {1'b0, o, p};
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
	endtask : do_reset

	// bad or dbg index of 8 means every byte is clean
	task automatic key_seq(input int bad, input int dbg);
		axw(`OFS_CONFIG, 32'h20, 1'b0, `RESP_OKAY);
		axr(`OFS_CONFIG, 32'h20, `RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			host.wr(16'hFFB0 + 16'(i), nv_key[8*i +: 8] ^ 8'(i == bad),
				i == dbg);
			@(negedge clock);
			chk(prog_start, 1'b0);
		end
		axw(`OFS_CONFIG, 32'h00, 1'b0, `RESP_OKAY);
		@(negedge clock);
	endtask : key_seq

	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		complete_run;
	end

	initial begin
		seed = 32'hb8807c01;
		{nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
		{debug_source, unsecured_req, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		nv_key = {$random(seed), $random(seed)};
		prot = {7'h40 | 7'($random(seed)), 1'b0};
		opt = {1'b1, 5'($random(seed)), 2'b11};
		{nv_option, nv_protect} = {opt, prot};
		do_reset(opt, prot);
		axr(`OFS_OPTION, {24'h0, opt}, `RESP_OKAY);
		chk(vector_redirect_en, !opt[6]);
		chk(secured, 1'b1);
		unsecured_req <= 1'b1;
		@(negedge clock);
		chk(access_block, 1'b1);
		axw(`OFS_OPTION, 32'hFF, 1'b1, `RESP_OKAY);
		axr(`OFS_OPTION, {24'h0, opt}, `RESP_OKAY);
		axr(`OFS_PROTECT, {24'h0, prot}, `RESP_OKAY);
		axr(8'h10, 32'h0, `RESP_SLVERR);
		// a config write without its low byte lane leaves steer clear
		wstrb <= 4'hE;
		axw(`OFS_CONFIG, 32'h20, 1'b0, `RESP_OKAY);
		axr(`OFS_CONFIG, 32'h0, `RESP_OKAY);
		wstrb <= 4'hF;
		for (int i = 0; i < 12; i++) begin
			wv = (i == 0) ? {prot[7:1] - 7'h1, 1'b1} : 8'($random(seed));
			d = (i < 2) ? i[0] : 1'($random(seed));
			axw(`OFS_PROTECT, {24'h0, wv}, d, `RESP_OKAY);
			prot = prot_next(prot, wv, d);
			axr(`OFS_PROTECT, {24'h0, prot}, `RESP_OKAY);
		end
		for (int i = 0; i < 6; i++) begin
			ca = (i < 2) ? {prot[7:1], 9'h1FF} + 16'(i) : 16'($random(seed));
			d = prot_hit(prot, ca);
			host.cmd(ca);
			@(negedge clock);
			chk({cmd_accept, cmd_refused}, {!d, d});
			chk(protection_violation_flag, d);
			axr(`OFS_STATUS, {30'h0, 1'b1, d}, `RESP_OKAY);
			axw(`OFS_STATUS, 32'h1, 1'b0, `RESP_OKAY);
		end
		wv = 8'($random(seed));
		host.wr(16'hFFB3, wv, 1'b0);
		@(negedge clock);
		chk({prog_start, prog_addr, prog_data}, {1'b1, 16'hFFB3, wv});
		key_seq(3, 8);
		chk(secured, 1'b1);
		key_seq(8, 5);
		chk(secured, 1'b1);
		key_seq(8, 8);
		chk(secured, 1'b0);
		chk(access_block, 1'b0);
		axr(`OFS_OPTION, {24'h0, opt[7:2], 2'b10}, `RESP_OKAY);
		opt = {1'b0, 5'($random(seed)), 2'b00};
		do_reset(opt, 8'h01);
		axr(`OFS_OPTION, {24'h0, opt}, `RESP_OKAY);
		chk(vector_redirect_en, !opt[6]);
		chk(secured, 1'b1);
		chk(access_block, 1'b1);
		key_seq(8, 8);
		chk(secured, 1'b1);
		host.cmd(16'hFFFF);
		@(negedge clock);
		chk({cmd_accept, cmd_refused}, 2'b10);
		axw(`OFS_PROTECT, 32'h0, 1'b1, `RESP_OKAY);
		axr(`OFS_PROTECT, 32'h01, `RESP_OKAY);
		host.blank(1'b0);
		@(negedge clock);
		chk(secured, 1'b1);
		host.blank(1'b1);
		@(negedge clock);
		chk(secured, 1'b0);
		complete_run;
	end
endmodule : tb_flash_security_protection
`default_nettype wire
